// [logic/wdt_defs.vh]
// Constants for the watchdog timer block: register indices, fields, resets.
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH

// Register indices; the byte address on the bus is four times the index.
`define WDT_IDX_CONTROL     16'h000f
`define WDT_IDX_OPTION      16'hffff
`define WDT_IDX_REFRESH     16'h0010
`define WDT_IDX_START       16'h0011
`define WDT_IDX_PROTECT     16'h0012
`define WDT_IDX_IRQ_STATUS  16'h0013
`define WDT_IDX_IRQ_MASK    16'h0014
`define WDT_IDX_SYS_CTRL    16'h0015

// Bus address width: index width plus the two byte-offset bits.
`define WDT_ADDR_W          18

// Counter width, reload value and the high-bit window in the control reg.
`define WDT_CNT_W           15
`define WDT_CNT_RELOAD      15'h7fff
`define WDT_CNT_HI_LSB      10

// Control register fields.
`define WDT_CTL_PRESCALE    7
`define WDT_CTL_RSVD6       6

// Option byte fields and reset value.
`define WDT_OPT_AUTOSTART   0
`define WDT_OPT_PROTECT     7
`define WDT_OPT_RESET       8'hff

// Protection register enable bit.
`define WDT_PROT_ENABLE     7

// System control register: underflow action select bit.
`define WDT_SYS_ACTION      0

// Interrupt status and mask bit for underflow.
`define WDT_IRQ_UNDERFLOW   0

// Refresh sequence bytes.
`define WDT_REFRESH_FIRST   8'h00
`define WDT_REFRESH_SECOND  8'hff

// Prescaler ratios, given as terminal counts of a 7-bit divider.
`define WDT_DIV16_LAST      7'h0f
`define WDT_DIV128_LAST     7'h7f

`endif

// [logic/wdt_prescaler.v]
// Prescaler that divides count-source ticks by 16 or by 128.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.vh"

module wdt_prescaler
(
   // Clock and reset.
   input  wire       clock,
   input  wire       resetn,
   // Count-source tick and control.
   input  wire       src_tick,
   input  wire       run,
   input  wire       ratio_128,
   // Divided tick, one cycle wide.
   output reg        div_tick
);

   reg  [6:0] div_count;
   wire [6:0] last_value;

   // The terminal count follows the ratio bit at once; a change mid-period
   // only costs one shortened or lengthened period.
   assign last_value = ratio_128 ? `WDT_DIV128_LAST : `WDT_DIV16_LAST;

   // The divider is cleared only by reset, never by a refresh, so a refresh
   // can shorten the first counter step by up to one prescaler period.
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         div_count <= 7'h00;
         div_tick  <= 1'b0;
      end
      else
      begin
         div_tick <= 1'b0;
         if (run && src_tick)
         begin
            if (div_count >= last_value)
            begin
               div_count <= 7'h00;
               div_tick  <= 1'b1;
            end
            else
            begin
               div_count <= div_count + 7'h01;
            end
         end
      end
   end

endmodule

`default_nettype wire

// [logic/wdt_timer.v]
// Watchdog timer with prescaler, refresh sequence and APB register access.
//
// What this block does
// - A 15-bit counter decrements once per prescaled count-source tick.
// - Protection off counts the CPU clock; protection on counts the oscillator.
// - Counting starts after reset, or waits for a start register write.
// - Stop and wait modes halt counting only while protection is off.
// - Reset, underflow or writing 00h then FFh reloads the counter.
// - Underflow gives interrupt or reset; with protection always a reset.
// - Option bit 0 clear starts counting after reset; set keeps it idle unless option bit 7 is clear.
// - Option bit 7 clear enables protection after reset; set disables it.
// - The option byte defaults to FFh: idle, protection off.
// - Control bits 4 to 0 are read-only high counter bits.
// - Control bit 7 selects divide-by-16 when 0, divide-by-128 when 1.
// - Control bits 5 and 6 written 0; reset value 00X11111b.
// - The period is the prescaler ratio times 32768 source cycles.
// - After stop or wait the counter resumes from its held value.
// - With protection off the action bit picks interrupt 0 or reset 1.
// - Program writes never change the option autostart bit.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.vh"

module wdt_timer
(
   // Clock and reset.
   input  wire                    clock,
   input  wire                    resetn,
   // APB slave.
   input  wire                    psel,
   input  wire                    penable,
   input  wire                    pwrite,
   input  wire [`WDT_ADDR_W-1:0]  paddr,
   input  wire [31:0]             pwdata,
   output reg  [31:0]             prdata,
   output reg                     pready,
   output reg                     pslverr,
   // System inputs.
   input  wire                    osc_low_clk,
   input  wire                    stop_mode,
   input  wire                    wait_mode,
   input  wire [7:0]              option_flash,
   input  wire                    flash_prog_we,
   // Watchdog outputs.
   output reg                     wdt_irq,
   output reg                     wdt_reset_req
);

   // Register index decoding, shared by read and write paths.
   function [15:0] reg_index;
      input [`WDT_ADDR_W-1:0] addr;
      begin
         reg_index = addr[`WDT_ADDR_W-1:2];
      end
   endfunction

   function known_index;
      input [15:0] idx;
      begin
         known_index = (idx == `WDT_IDX_CONTROL)
                    || (idx == `WDT_IDX_OPTION)
                    || (idx == `WDT_IDX_REFRESH)
                    || (idx == `WDT_IDX_START)
                    || (idx == `WDT_IDX_PROTECT)
                    || (idx == `WDT_IDX_IRQ_STATUS)
                    || (idx == `WDT_IDX_IRQ_MASK)
                    || (idx == `WDT_IDX_SYS_CTRL);
      end
   endfunction

   // State held by the block.
   reg  [`WDT_CNT_W-1:0] count;
   reg                   prescale_select;
   reg                   ctl_rsvd6;
   reg  [7:0]            option_byte;
   reg                   boot_pending;
   reg                   running;
   reg                   protect_mode;
   reg                   underflow_action_select;
   reg                   refresh_armed;
   reg                   irq_status;
   reg                   irq_mask;
   reg                   osc_prev;

   wire [15:0]           idx;
   wire                  setup_rd;
   wire                  wr_take;
   wire                  src_tick;
   wire                  halted;
   wire                  div_tick;
   wire                  refresh_hit;
   wire                  underflow;
   wire                  wr_control;
   wire                  wr_option;
   wire                  wr_refresh;
   wire                  wr_start;
   wire                  wr_protect;
   wire                  wr_status;
   wire                  wr_mask;
   wire                  wr_sys;
   wire [7:0]            wbyte;

   // One wait state: data is prepared in the first access cycle and the
   // write commits on the edge where the master sees pready high.
   assign idx      = reg_index(paddr);
   assign setup_rd = psel && penable && !pready;
   assign wr_take  = psel && penable && pready && pwrite;
   assign wbyte    = pwdata[7:0];

   assign wr_control = wr_take && (idx == `WDT_IDX_CONTROL);
   assign wr_option  = wr_take && (idx == `WDT_IDX_OPTION);
   assign wr_refresh = wr_take && (idx == `WDT_IDX_REFRESH);
   assign wr_start   = wr_take && (idx == `WDT_IDX_START);
   assign wr_protect = wr_take && (idx == `WDT_IDX_PROTECT);
   assign wr_status  = wr_take && (idx == `WDT_IDX_IRQ_STATUS);
   assign wr_mask    = wr_take && (idx == `WDT_IDX_IRQ_MASK);
   assign wr_sys     = wr_take && (idx == `WDT_IDX_SYS_CTRL);

   // Oscillator edges are detected on the CPU clock; the oscillator must run
   // well below half the CPU rate or edges are missed.
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         osc_prev <= 1'b0;
      else
         osc_prev <= osc_low_clk;
   end

   assign src_tick = protect_mode ? (osc_low_clk && !osc_prev) : 1'b1;

   assign halted = (stop_mode || wait_mode) && !protect_mode;

   wdt_prescaler u_prescaler
   (
      .clock     (clock),
      .resetn    (resetn),
      .src_tick  (src_tick),
      .run       (running && !halted),
      .ratio_128 (prescale_select),
      .div_tick  (div_tick)
   );

   assign refresh_hit = wr_refresh && refresh_armed
                        && (wbyte == `WDT_REFRESH_SECOND);

   assign underflow = div_tick && running && !halted
                      && (count == {`WDT_CNT_W{1'b0}});

   // Refresh sequence tracker; any other byte breaks the sequence.
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         refresh_armed <= 1'b0;
      else if (wr_refresh)
         refresh_armed <= (wbyte == `WDT_REFRESH_FIRST);
   end

   // A halt simply holds the value.
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         count <= `WDT_CNT_RELOAD;
      else if (refresh_hit || underflow)
         count <= `WDT_CNT_RELOAD;
      else if (div_tick && running && !halted)
         count <= count - {{(`WDT_CNT_W-1){1'b0}}, 1'b1};
   end

   // Autostart bit kept from programs.
   // The flash image is caught on the first edge after reset release.
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         option_byte  <= `WDT_OPT_RESET;
         boot_pending <= 1'b1;
      end
      else
      begin
         boot_pending <= 1'b0;
         if (boot_pending || flash_prog_we)
            option_byte <= option_flash;
         else if (wr_option)
            option_byte <= {wbyte[7:1], option_byte[`WDT_OPT_AUTOSTART]};
      end
   end

   // Start automatically or on start write.
   // Protection bit sampled at boot.
   // Protection, once on, cannot be turned off by software.
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         running      <= 1'b0;
         protect_mode <= 1'b0;
      end
      else if (boot_pending)
      begin
         running      <= !option_flash[`WDT_OPT_AUTOSTART]
                         || !option_flash[`WDT_OPT_PROTECT];
         protect_mode <= !option_flash[`WDT_OPT_PROTECT];
      end
      else
      begin
         if (wr_start)
            running <= 1'b1;
         if (wr_protect && wbyte[`WDT_PROT_ENABLE])
         begin
            protect_mode <= 1'b1;
            running      <= 1'b1;
         end
      end
   end

   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         prescale_select         <= 1'b0;
         ctl_rsvd6               <= 1'b0;
         underflow_action_select <= 1'b0;
         irq_mask                <= 1'b0;
      end
      else
      begin
         if (wr_control)
         begin
            prescale_select <= wbyte[`WDT_CTL_PRESCALE];
            ctl_rsvd6       <= wbyte[`WDT_CTL_RSVD6];
         end
         if (wr_sys)
            underflow_action_select <= wbyte[`WDT_SYS_ACTION];
         if (wr_mask)
            irq_mask <= wbyte[`WDT_IRQ_UNDERFLOW];
      end
   end

   // One request per underflow.
   // A new underflow wins over a write-one-to-clear in the same cycle.
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         irq_status    <= 1'b0;
         wdt_reset_req <= 1'b0;
         wdt_irq       <= 1'b0;
      end
      else
      begin
         wdt_reset_req <= underflow
                          && (protect_mode || underflow_action_select);
         if (underflow && !protect_mode && !underflow_action_select)
            irq_status <= 1'b1;
         else if (wr_status && wbyte[`WDT_IRQ_UNDERFLOW])
            irq_status <= 1'b0;
         wdt_irq <= irq_status && irq_mask;
      end
   end

   // Read data, ready and error are all prepared in the first access cycle.
   // Counter high bits readable.
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else if (setup_rd)
      begin
         pready  <= 1'b1;
         pslverr <= !known_index(idx);
         prdata  <= 32'h00000000;
         if (!pwrite)
         begin
            case (idx)
               `WDT_IDX_CONTROL:
                  prdata[7:0] <= {prescale_select, ctl_rsvd6, 1'b0,
                                  count[`WDT_CNT_W-1:`WDT_CNT_HI_LSB]};
               `WDT_IDX_OPTION:
                  prdata[7:0] <= option_byte;
               `WDT_IDX_START:
                  prdata[0] <= running;
               `WDT_IDX_PROTECT:
                  prdata[`WDT_PROT_ENABLE] <= protect_mode;
               `WDT_IDX_IRQ_STATUS:
                  prdata[`WDT_IRQ_UNDERFLOW] <= irq_status;
               `WDT_IDX_IRQ_MASK:
                  prdata[`WDT_IRQ_UNDERFLOW] <= irq_mask;
               `WDT_IDX_SYS_CTRL:
                  prdata[`WDT_SYS_ACTION] <= underflow_action_select;
               default:
                  prdata <= 32'h00000000;
            endcase
         end
      end
      else
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// [bench/wdt_chk_assertions.sv]
// Checker for the watchdog bus answers and the reset request pulse.
`timescale 1ns/1ps
`default_nettype none
module wdt_chk
(
   // Clock and reset.
   input wire logic        clock,
   input wire logic        resetn,
   // Bus.
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Watchdog outputs.
   input wire logic        wdt_reset_req
);
   // All checks share the one clock, so one default suffices.
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   one_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("wait state count wrong");
   ready_cause_a: assert property (pready |-> $past(psel && penable))
      else $error("ready without access");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   data_upper_a: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   ctl_bit5_a: assert property (pready && $past(!pwrite &&
      paddr == 18'h0003c) |-> !prdata[5])
      else $error("control bit 5 set");
   rfsh_read_a: assert property (pready && $past(!pwrite &&
      paddr == 18'h00040) |-> prdata == 32'h0)
      else $error("refresh read not zero");
   reset_pulse_a: assert property (wdt_reset_req |=> !wdt_reset_req)
      else $error("reset request too long");

   // Main scenarios reached.
   cover property (pready && pslverr);
   cover property (pready && $past(!pwrite && paddr == 18'h0003c));
   cover property (pready && $past(pwrite && paddr == 18'h00040));
endmodule

bind wdt_timer wdt_chk wdt_chk_inst (.clock(clock), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .wdt_reset_req(wdt_reset_req));
`default_nettype wire

// [bench/wdt_timer_tb.sv]
// Self-checking bench for the watchdog timer block.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.vh"
module wdt_timer_tb;
   logic        clock, resetn, psel, penable, pwrite, er;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, osc_low_clk, stop_mode, wait_mode;
   logic [7:0]  option_flash, rnd;
   logic        flash_prog_we, wdt_irq, wdt_reset_req;
   int          error_cnt, checks, cyc;

   wdt_timer wdt_timer_inst (.clock(clock), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .osc_low_clk(osc_low_clk), .stop_mode(stop_mode),
      .wait_mode(wait_mode), .option_flash(option_flash),
      .flash_prog_we(flash_prog_we), .wdt_irq(wdt_irq),
      .wdt_reset_req(wdt_reset_req));

   // Clocks: system at 50 MHz, oscillator at an eighth of it.
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial
   begin
      osc_low_clk = 1'b0;
      forever #80 osc_low_clk = ~osc_low_clk;
   end

   task automatic close_out;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // A hang costs a mismatch and ends the run.
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         error_cnt++;
         close_out;
      end
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Model of the control read: reload minus elapsed prescaled ticks.
   function automatic logic [31:0] m_ctl(input int cy, input int n,
                                         input logic ps);
      int c;
      c = 32767 - cy / n;
      m_ctl = {24'h0, ps, 2'b00, c[14:10]};
   endfunction

   // One transfer; the request holds until ready is sampled high.
   task automatic apb(input logic w, input logic [15:0] i,
                      input logic [7:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clock);
      penable <= 1'b1;
      // Ready is registered, so sampling it at the falling edge avoids a race
      // with its own launch edge; the values stand through the next rise.
      @(negedge clock);
      while (pready !== 1'b1)
         @(negedge clock);
      rd = prdata;
      er = pslverr;
      // The request is released only after the edge that sees ready high.
      @(posedge clock);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rck(input logic [15:0] i, input logic [31:0] exp);
      apb(1'b0, i, 8'h00);
      cmp(rd, exp);
   endtask

   task automatic rst(input logic [7:0] f);
      @(posedge clock);
      resetn <= 1'b0;
      option_flash <= f;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
   endtask

   initial
   begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 18'h0;
      pwdata = 32'h0;
      stop_mode = 1'b0;
      wait_mode = 1'b0;
      option_flash = 8'hff;
      flash_prog_we = 1'b0;
      void'($urandom(32'h45f4));
      rst(`WDT_OPT_RESET);
      // Erased option byte leaves the counter idle.
      rck(`WDT_IDX_OPTION, 32'hff);
      rck(`WDT_IDX_CONTROL, 32'h1f);
      rck(`WDT_IDX_START, 32'h0);
      rck(`WDT_IDX_PROTECT, 32'h0);
      repeat (17000) @(posedge clock);
      rck(`WDT_IDX_CONTROL, 32'h1f);
      // Only flash programming moves the start bit.
      apb(1'b1, `WDT_IDX_OPTION, 8'hfe);
      rck(`WDT_IDX_OPTION, 32'hff);
      option_flash <= 8'hfe;
      flash_prog_we <= 1'b1;
      @(posedge clock);
      flash_prog_we <= 1'b0;
      rck(`WDT_IDX_OPTION, 32'hfe);
      // A cleared start bit counts from reset.
      rst(8'hfe);
      rck(`WDT_IDX_START, 32'h1);
      repeat (16600) @(posedge clock);
      rck(`WDT_IDX_CONTROL, m_ctl(16620, 16, 1'b0));
      // Only 00h then FFh reloads the counter.
      apb(1'b1, `WDT_IDX_REFRESH, `WDT_REFRESH_SECOND);
      rck(`WDT_IDX_CONTROL, 32'h1e);
      apb(1'b1, `WDT_IDX_REFRESH, `WDT_REFRESH_FIRST);
      apb(1'b1, `WDT_IDX_REFRESH, `WDT_REFRESH_SECOND);
      rck(`WDT_IDX_CONTROL, 32'h1f);
      // Stop and wait both halt the unprotected count.
      stop_mode <= 1'b1;
      repeat (8500) @(posedge clock);
      stop_mode <= 1'b0;
      wait_mode <= 1'b1;
      repeat (8500) @(posedge clock);
      wait_mode <= 1'b0;
      rck(`WDT_IDX_CONTROL, 32'h1f);
      // Divide by 128 keeps the high bits over this wait.
      apb(1'b1, `WDT_IDX_CONTROL, 8'h80);
      apb(1'b1, `WDT_IDX_REFRESH, `WDT_REFRESH_FIRST);
      apb(1'b1, `WDT_IDX_REFRESH, `WDT_REFRESH_SECOND);
      repeat (16600) @(posedge clock);
      rck(`WDT_IDX_CONTROL, m_ctl(16620, 128, 1'b1));
      // Interrupt mask, clear and action registers.
      rnd = 8'($urandom());
      apb(1'b1, `WDT_IDX_IRQ_MASK, rnd);
      rck(`WDT_IDX_IRQ_MASK, {31'h0, rnd[0]});
      apb(1'b1, `WDT_IDX_IRQ_STATUS, 8'h01);
      rck(`WDT_IDX_IRQ_STATUS, 32'h0);
      cmp({31'h0, wdt_irq}, 32'h0);
      apb(1'b1, `WDT_IDX_SYS_CTRL, 8'h01);
      rck(`WDT_IDX_SYS_CTRL, 32'h1);
      // An unmapped place is refused.
      apb(1'b1, 16'h0100, 8'($urandom()));
      cmp({31'h0, er}, 32'h1);
      rck(16'h0100, 32'h0);
      // Protection turns on and cannot be turned off.
      apb(1'b1, `WDT_IDX_PROTECT, 8'h80);
      apb(1'b1, `WDT_IDX_PROTECT, 8'h00);
      rck(`WDT_IDX_PROTECT, 32'h80);
      // A cleared protect bit turns protection on at boot.
      rst(8'h7f);
      rck(`WDT_IDX_PROTECT, 32'h80);
      rck(`WDT_IDX_START, 32'h1);
      // Protected, the count follows the slow oscillator, eight
      // clocks a tick, so the high bits must not yet have moved.
      repeat (16600) @(posedge clock);
      rck(`WDT_IDX_CONTROL, m_ctl(16620, 128, 1'b0));
      // No underflow can fall inside this run, so no reset request.
      cmp({31'h0, wdt_reset_req}, 32'h0);
      close_out;
   end
endmodule
`default_nettype wire
